// [pdcs_consts.vh]
// Contract
// - Control bits 0..3 are read-write, reset zero, each gating one error class report.
// - Relaxed ordering enable bit 4 reads zero; originated requests never carry relaxed ordering.
// - Payload limit bits 7:5 read-write, reset zero; codes 0..4 select 128..2048 bytes.
// - Reserved payload codes 5, 6 and 7 behave exactly like the 128-byte limit.
// - Wide tag enable bit 8 is read-write, reset zero, inert in normal operation.
// - With debug sequential tags on, tags span 0..31, or 0..255 with wide tags.
// - Phantom function enable bit 9 is hardwired zero and read-only.
// - Auxiliary power management enable bit 10 is read-only and reads zero.
// - No-snoop enable bit 11 reads zero; never originated, forwarded attribute unchanged.
// - Read request size bits 14:12 read zero; origination capped at 128 bytes.
// - Status bit 0 sets on any correctable error; write one clears it.
// - Status bit 1 sets on any non-fatal error; reset zero; write one clears.
// - Status bit 2 sets on any fatal error; reset zero; write one clears.
// - Status bit 3 sets on unsupported request received; reset zero; write one clears.
// - Auxiliary power detected status bit 4 is read-only and always zero.
// - Transactions pending status bit 5 is read-only and always zero.
`ifndef PDCS_CONSTS_VH
`define PDCS_CONSTS_VH

// Byte offsets; control and status share one 32-bit word, status in its upper half.
`define PDCS_OFS_DEVICE_CONTROL 12'h048
`define PDCS_OFS_DEVICE_STATUS 12'h04a
`define PDCS_OFS_TL_CONTROL 12'h100
`define PDCS_OFS_IRQ_STATUS 12'h104
`define PDCS_OFS_IRQ_MASK 12'h108
`define PDCS_STS_LSB 16
`define PDCS_PAYLOAD_MIN_BYTES 12'h080

`define PDCS_RESET_VALUE 16'h0000

// Writable bits of device_control: bits 3:0, 7:5 and 8.
`define PDCS_CTL_WMASK 16'h01ef
// Status bits that hardware sets and software clears with ones.
`define PDCS_STS_W1C_MASK 16'h000f

`define PDCS_CTL_ERR_EN_LSB 0
`define PDCS_CTL_PAYLOAD_LSB 5
`define PDCS_CTL_WIDE_TAG_BIT 8

`define PDCS_PAYLOAD_128 3'h0
`define PDCS_PAYLOAD_2048 3'h4

`define PDCS_TAG_NARROW_MAX 8'h1f
`define PDCS_TAG_WIDE_MAX 8'hff
`define PDCS_ORIG_READ_MAX_BYTES 12'h080

`endif

// [pdcs_ctrl_status.v]
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "pdcs_consts.vh"

module pdcs_ctrl_status #(
	parameter ADDR_W = 12
) (
	input wire i_mclk,
	input wire i_reset_n,
	// Wishbone classic slave, byte addressed, 32-bit data.
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [ADDR_W-1:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output wire o_wb_ack,
	output wire [31:0] o_wb_dat,
	// Error detection pulses, one per detected error.
	input wire i_corr_err,
	input wire i_nonfatal_err,
	input wire i_fatal_err,
	input wire i_unsupp_req,
	// Error message requests, only for enabled classes.
	output wire [3:0] o_err_report,
	// Effective maximum payload in bytes.
	output wire [11:0] o_max_payload_bytes,
	// Tag generator for debug sequential tagging.
	input wire i_tag_take,
	output wire [7:0] o_tag,
	// Attributes of requests the port originates and forwards.
	input wire i_fwd_no_snoop,
	input wire i_fwd_relaxed_order,
	input wire [9:0] i_fwd_length,
	output wire o_fwd_no_snoop,
	output wire o_fwd_relaxed_order,
	output wire [9:0] o_fwd_length,
	output wire o_orig_relaxed_order,
	output wire o_orig_no_snoop,
	output wire [11:0] o_orig_read_max_bytes,
	output wire o_irq
);

	// Byte offsets of the register words; address bits 1:0 are ignored and the byte selects pick the lanes.
	localparam [ADDR_W-1:0] OFS_DEV = `PDCS_OFS_DEVICE_CONTROL;
	localparam [ADDR_W-1:0] OFS_STS = `PDCS_OFS_DEVICE_STATUS;
	localparam [ADDR_W-1:0] OFS_TLC = `PDCS_OFS_TL_CONTROL;
	localparam [ADDR_W-1:0] OFS_IRQ_STS = `PDCS_OFS_IRQ_STATUS;
	localparam [ADDR_W-1:0] OFS_IRQ_MSK = `PDCS_OFS_IRQ_MASK;
	localparam NUM_EVT = 4;

	// Bus handshake states.
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK = 2'b10;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [31:0] rdat_ff;
	reg [31:0] nxt_rdat;
	reg [3:0] ctl_err_en_ff;
	reg [2:0] ctl_payload_ff;
	reg ctl_wide_tag_ff;
	reg [3:0] sts_ff;
	reg seq_tag_ff;
	reg [3:0] irq_sts_ff;
	reg [3:0] irq_mask_ff;
	reg [3:0] rep_ff;
	reg [7:0] tag_ff;
	reg [7:0] nxt_tag;
	reg [11:0] payload_bytes_ff;
	reg fwd_ns_ff;
	reg fwd_ro_ff;
	reg [9:0] fwd_len_ff;

	wire req;
	wire in_idle;
	wire in_ack;
	wire wr_now;
	wire rd_now;
	wire take_rd;
	wire hit_dev;
	wire hit_sts;
	wire hit_tlc;
	wire hit_irq_sts;
	wire hit_irq_msk;
	wire wr_dev;
	wire wr_sts;
	wire wr_tlc;
	wire wr_irq_msk;
	wire [15:0] ctl_wmask;
	wire [15:0] sts_wmask;
	wire [15:0] ctl_wdat;
	wire [15:0] sts_wdat;
	wire [15:0] ctl_merged;
	wire [15:0] sts_clr_bits;
	wire [3:0] events;
	wire [3:0] sts_clr;
	wire irq_clr;
	wire [3:0] nxt_sts;
	wire [3:0] nxt_irq_sts;
	wire [3:0] nxt_rep;
	wire [15:0] ctl_view;
	wire [15:0] sts_view;
	wire [7:0] tag_max;
	wire tag_over;
	wire tag_wrap;

	// Maps a payload code to bytes; reserved codes fall back to the smallest size.
	function [11:0] payload_bytes;
		input [2:0] code;
		begin
			if (code > `PDCS_PAYLOAD_2048) begin
				payload_bytes = `PDCS_PAYLOAD_MIN_BYTES;
			end else begin
				payload_bytes = `PDCS_PAYLOAD_MIN_BYTES << code;
			end
		end
	endfunction

	// Word decode shared by the read mux, the write strobes and the clear strobes.
	function is_word;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] ofs;
		begin
			is_word = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
		end
	endfunction

	// Expands the two byte selects of one 16-bit half into a bit mask.
	function [15:0] lane_mask;
		input [1:0] lanes;
		begin
			lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
		end
	endfunction

	assign req = i_wb_cyc & i_wb_stb;
	assign in_idle = (state_ff == ST_IDLE);
	assign in_ack = (state_ff == ST_ACK);
	// The answer comes one cycle after the request; the write and the read side effect
	// act at the edge where the master samples ack, so a held request acts only once.
	assign wr_now = req & in_ack & i_wb_we;
	assign rd_now = req & in_ack & ~i_wb_we;
	assign take_rd = req & in_idle & ~i_wb_we;

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (req) begin
					nxt_state = ST_ACK;
				end
			end
			ST_ACK: begin
				// Ack lasts one cycle even if the master keeps its strobe up.
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	assign hit_dev = is_word(i_wb_adr, OFS_DEV);
	assign hit_sts = is_word(i_wb_adr, OFS_STS);
	assign hit_tlc = is_word(i_wb_adr, OFS_TLC);
	assign hit_irq_sts = is_word(i_wb_adr, OFS_IRQ_STS);
	assign hit_irq_msk = is_word(i_wb_adr, OFS_IRQ_MSK);
	assign wr_dev = wr_now & hit_dev;
	assign wr_sts = wr_now & hit_sts;
	assign wr_tlc = wr_now & hit_tlc & i_wb_sel[0];
	assign wr_irq_msk = wr_now & hit_irq_msk & i_wb_sel[0];

	// Control sits in lanes 1:0 and status in lanes 3:2 of the shared word.
	assign ctl_wmask = lane_mask(i_wb_sel[1:0]);
	assign sts_wmask = lane_mask(i_wb_sel[3:2]);
	assign ctl_wdat = i_wb_dat[15:0];
	assign sts_wdat = i_wb_dat[`PDCS_STS_LSB +: 16];
	// Unselected lanes keep their value, so a byte write touches only its own fields.
	assign ctl_merged = (ctl_view & ~ctl_wmask) | (ctl_wdat & ctl_wmask);
	assign sts_clr_bits = sts_wdat & sts_wmask & `PDCS_STS_W1C_MASK;
	assign sts_clr = wr_sts ? sts_clr_bits[3:0] : 4'h0;
	assign irq_clr = rd_now & hit_irq_sts;

	assign events = {i_unsupp_req, i_fatal_err, i_nonfatal_err, i_corr_err};

	// Read-only fields are built from constants, so nothing a write does can show.
	assign ctl_view = {
		4'h0,
		1'b0,
		1'b0,
		1'b0,
		ctl_wide_tag_ff,
		ctl_payload_ff,
		1'b0,
		ctl_err_en_ff
	};
	assign sts_view = {
		10'h000,
		1'b0,
		1'b0,
		sts_ff
	};

	assign o_wb_ack = in_ack;
	assign o_wb_dat = rdat_ff;
	assign o_err_report = rep_ff;
	assign o_max_payload_bytes = payload_bytes_ff;
	assign o_tag = tag_ff;
	assign o_fwd_no_snoop = fwd_ns_ff;
	assign o_fwd_relaxed_order = fwd_ro_ff;
	assign o_fwd_length = fwd_len_ff;
	assign o_orig_relaxed_order = 1'b0;
	assign o_orig_no_snoop = 1'b0;
	assign o_orig_read_max_bytes = `PDCS_ORIG_READ_MAX_BYTES;
	assign o_irq = |(irq_sts_ff & irq_mask_ff);

	always @* begin
		nxt_rdat = 32'h0000_0000;
		if (hit_dev) begin
			nxt_rdat = {sts_view, ctl_view};
		end else if (hit_tlc) begin
			nxt_rdat = {31'h0000_0000, seq_tag_ff};
		end else if (hit_irq_sts) begin
			nxt_rdat = {28'h000_0000, irq_sts_ff};
		end else if (hit_irq_msk) begin
			nxt_rdat = {28'h000_0000, irq_mask_ff};
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_EVT; g = g + 1) begin : g_evt
			// A detection in the clearing cycle wins over the clear, so none is lost.
			assign nxt_sts[g] = events[g] | (sts_ff[g] & ~sts_clr[g]);
			assign nxt_irq_sts[g] = events[g] | (irq_sts_ff[g] & ~irq_clr);
			// Logging ignores the enable; only the outgoing report is gated.
			assign nxt_rep[g] = events[g] & ctl_err_en_ff[g];
		end
	endgenerate

	assign tag_max = ctl_wide_tag_ff ? `PDCS_TAG_WIDE_MAX : `PDCS_TAG_NARROW_MAX;
	assign tag_over = (tag_ff > tag_max);
	assign tag_wrap = (tag_ff == tag_max);

	// Clearing the wide tag bit with a tag above 31 in hand restarts the count at zero,
	// so the tag sits above the narrow range for one cycle at most while the debug setting stays on.
	always @* begin
		nxt_tag = tag_ff;
		if (!seq_tag_ff) begin
			nxt_tag = 8'h00;
		end else if (tag_over) begin
			nxt_tag = 8'h00;
		end else if (i_tag_take) begin
			if (tag_wrap) begin
				nxt_tag = 8'h00;
			end else begin
				nxt_tag = tag_ff + 8'h01;
			end
		end
	end

	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_ff <= ST_IDLE;
			rdat_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			// Read data stands only in the ack cycle and is zero otherwise.
			rdat_ff <= take_rd ? nxt_rdat : 32'h0000_0000;
		end
	end

	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl_err_en_ff <= 4'h0;
			ctl_payload_ff <= 3'h0;
			ctl_wide_tag_ff <= 1'b0;
		end else if (wr_dev) begin
			ctl_err_en_ff <= ctl_merged[3:0];
			ctl_payload_ff <= ctl_merged[`PDCS_CTL_PAYLOAD_LSB +: 3];
			ctl_wide_tag_ff <= ctl_merged[`PDCS_CTL_WIDE_TAG_BIT];
		end
	end

	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seq_tag_ff <= 1'b0;
		end else if (wr_tlc) begin
			seq_tag_ff <= i_wb_dat[0];
		end
	end

	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_mask_ff <= 4'h0;
		end else if (wr_irq_msk) begin
			irq_mask_ff <= i_wb_dat[3:0];
		end
	end

	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sts_ff <= 4'h0;
			irq_sts_ff <= 4'h0;
			rep_ff <= 4'h0;
		end else begin
			sts_ff <= nxt_sts;
			irq_sts_ff <= nxt_irq_sts;
			rep_ff <= nxt_rep;
		end
	end

	// The byte limit is registered so downstream logic sees a clean value.
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			payload_bytes_ff <= `PDCS_PAYLOAD_MIN_BYTES;
		end else begin
			payload_bytes_ff <= payload_bytes(ctl_payload_ff);
		end
	end

	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tag_ff <= 8'h00;
		end else begin
			tag_ff <= nxt_tag;
		end
	end

	// Forwarded attributes pass through one register stage and are never altered.
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fwd_ns_ff <= 1'b0;
			fwd_ro_ff <= 1'b0;
			fwd_len_ff <= 10'h000;
		end else begin
			fwd_ns_ff <= i_fwd_no_snoop;
			fwd_ro_ff <= i_fwd_relaxed_order;
			fwd_len_ff <= i_fwd_length;
		end
	end

endmodule

// [pdcs_ctrl_status_assertions.sv]
`timescale 1ns/1ps
module pdcs_chk (
	input logic i_mclk,
	input logic i_reset_n,
	input logic i_wb_cyc,
	input logic i_wb_stb,
	input logic o_wb_ack,
	input logic [31:0] o_wb_dat,
	input logic i_corr_err,
	input logic i_nonfatal_err,
	input logic i_fatal_err,
	input logic i_unsupp_req,
	input logic [3:0] o_err_report,
	input logic [11:0] o_max_payload_bytes,
	input logic [7:0] o_tag,
	input logic [9:0] i_fwd_length,
	input logic [9:0] o_fwd_length,
	input logic i_fwd_no_snoop,
	input logic o_fwd_no_snoop,
	input logic o_orig_relaxed_order,
	input logic o_orig_no_snoop,
	input logic [11:0] o_orig_read_max_bytes
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence s_req;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_answer;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	property p_ack;
		s_req |=> s_answer;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer late or too long");
	property p_hi_zero;
		o_wb_ack |-> o_wb_dat[31:20] == 12'h0 && o_wb_dat[15:9] == 7'h0 && !o_wb_dat[4];
	endproperty
	a_hi_zero: assert property (p_hi_zero)
		else $error("read-only read data not zero");
	// A report without a detected error in the cycle before is never legal.
	property p_report;
		o_err_report != 4'h0 |-> (o_err_report & ~$past({i_unsupp_req, i_fatal_err,
			i_nonfatal_err, i_corr_err})) == 4'h0;
	endproperty
	a_report: assert property (p_report)
		else $error("error report without an event");
	property p_orig;
		!o_orig_relaxed_order && !o_orig_no_snoop;
	endproperty
	a_orig: assert property (p_orig)
		else $error("originated attribute set");
	property p_read_max;
		o_orig_read_max_bytes == 12'h080;
	endproperty
	a_read_max: assert property (p_read_max)
		else $error("originated read size wrong");
	property p_fwd;
		o_fwd_length == $past(i_fwd_length) && o_fwd_no_snoop == $past(i_fwd_no_snoop);
	endproperty
	a_fwd: assert property (p_fwd)
		else $error("forwarded attribute altered");
	property p_payload;
		$onehot(o_max_payload_bytes) && o_max_payload_bytes[6:0] == 7'h0;
	endproperty
	a_payload: assert property (p_payload)
		else $error("payload limit not a legal size");
	property p_tag;
		$changed(o_tag) && o_tag != 8'h0 |-> o_tag == $past(o_tag) + 8'h1;
	endproperty
	a_tag: assert property (p_tag)
		else $error("tag skipped a value");
endmodule
bind pdcs_ctrl_status pdcs_chk u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
	.i_corr_err(i_corr_err), .i_nonfatal_err(i_nonfatal_err), .i_fatal_err(i_fatal_err),
	.i_unsupp_req(i_unsupp_req), .o_err_report(o_err_report),
	.o_max_payload_bytes(o_max_payload_bytes), .o_tag(o_tag), .i_fwd_length(i_fwd_length),
	.o_fwd_length(o_fwd_length), .i_fwd_no_snoop(i_fwd_no_snoop),
	.o_fwd_no_snoop(o_fwd_no_snoop), .o_orig_relaxed_order(o_orig_relaxed_order),
	.o_orig_no_snoop(o_orig_no_snoop), .o_orig_read_max_bytes(o_orig_read_max_bytes));

// [test_pcie_device_ctrl_status.sv]
`timescale 1ns/1ps
module test_pcie_device_ctrl_status;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, take = 0, ns = 0, ro = 0;
	logic [11:0] adr = 0;
	logic [31:0] wdat = 0, rd, rdat;
	logic [3:0] sel = 0, err = 0, rep;
	logic [9:0] len = 0, flen;
	logic ack, irq, fns, fro, ors, ons;
	logic [11:0] pay, orm;
	logic [7:0] tag;
	int fail_count = 0, tests_run = 0, cycles = 0;
	pdcs_ctrl_status dut (.i_mclk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack),
		.o_wb_dat(rdat), .i_corr_err(err[0]), .i_nonfatal_err(err[1]), .i_fatal_err(err[2]),
		.i_unsupp_req(err[3]), .o_err_report(rep), .o_max_payload_bytes(pay),
		.i_tag_take(take), .o_tag(tag), .i_fwd_no_snoop(ns), .i_fwd_relaxed_order(ro),
		.i_fwd_length(len), .o_fwd_no_snoop(fns), .o_fwd_relaxed_order(fro),
		.o_fwd_length(flen), .o_orig_relaxed_order(ors), .o_orig_no_snoop(ons),
		.o_orig_read_max_bytes(orm), .o_irq(irq));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			finish_test();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	// Outputs are read in the edge's wake-up, so they show what that edge sampled.
	task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= a[1] ? d << 16 : d;
		sel <= a[1] ? 4'hc : 4'h3;
		do @(posedge clk); while (ack !== 1'b1);
		rd = a[1] ? rdat >> 16 : rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task rd_chk(input logic [11:0] a, input logic [31:0] e);
		wb(0, a, 32'h0);
		chk(rd, e);
	endtask
	task t_reset;
		chk(pay, 32'h080);
		rd_chk(12'h048, 32'h0);
		rd_chk(12'h04a, 32'h0);
		rd_chk(12'h3fc, 32'h0);
		wb(1, 12'h048, 32'hffffffff);
		rd_chk(12'h048, 32'h1ef);
	endtask
	task t_payload;
		for (int c = 0; c < 8; c++) begin
			wb(1, 12'h048, c << 5);
			repeat (2) @(posedge clk);
			chk(pay, c < 5 ? 32'h080 << c : 32'h080);
		end
	endtask
	task t_errors;
		wb(1, 12'h048, 32'h5);
		err <= 4'hf;
		@(posedge clk);
		err <= 4'h0;
		@(posedge clk);
		chk(rep, 32'h5);
		chk(irq, 32'h0);
		rd_chk(12'h04a, 32'hf);
		wb(1, 12'h04a, 32'hfff0);
		rd_chk(12'h04a, 32'hf);
		wb(1, 12'h04a, 32'h5);
		rd_chk(12'h04a, 32'ha);
		wb(1, 12'h108, 32'h4);
		repeat (2) @(posedge clk);
		chk(irq, 32'h1);
		rd_chk(12'h104, 32'hf);
		repeat (2) @(posedge clk);
		chk(irq, 32'h0);
	endtask
	task t_tag;
		wb(1, 12'h100, 32'h1);
		take <= 1;
		repeat (33) @(posedge clk);
		take <= 0;
		@(posedge clk);
		chk(tag, 32'h01);
		wb(1, 12'h048, 32'h100);
		rd_chk(12'h048, 32'ha0100);
		take <= 1;
		repeat (40) @(posedge clk);
		take <= 0;
		@(posedge clk);
		chk(tag, 32'h29);
		len <= 10'h2a5;
		ns <= 1;
		ro <= 1;
		repeat (2) @(posedge clk);
		chk({flen, fns, fro, ors, ons, orm}, {10'h2a5, 4'hc, 12'h080});
	endtask
	task finish_test;
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_payload();
		t_errors();
		t_tag();
		finish_test();
	end
endmodule
